//--- sacs_sequencer.sv
// Purpose: Conversion sequencer for an 8-bit successive-approximation converter
// Assumes: Analog side returns its result and over-range flag as async levels
// Notes: All timing runs on converter strobes from the prescaler
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sacs_sequencer
   import sacs_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire sacs_axi_req_t S_AXI_REQ,
   output sacs_axi_rsp_t S_AXI_RSP,
   input wire logic [6:0] TRIG_IN,
   input wire logic [7:0] CMP_RESULT,
   input wire logic CMP_OVER,
   input wire logic SLEEP_HALT,
   output logic ANALOG_ENABLE,
   output logic [1:0] MUX_SEL,
   output logic SAMPLE_HOLD,
   output logic CONV_ACTIVE,
   output logic CONV_IRQ
);
   logic [15:0] sync_out;
   logic [6:0] trig_s;
   logic [7:0] cmp_s;
   logic over_s;
   logic tick;

   sacs_sync #(.W(16)) u_sync (
      .clk(SYS_CLK),
      .rst(RST),
      .din({TRIG_IN, CMP_OVER, CMP_RESULT}),
      .dout(sync_out)
   );
   assign cmp_s = sync_out[7:0];
   assign over_s = sync_out[8];
   assign trig_s = sync_out[15:9];

   // Bus slave state
   sacs_axi_rsp_t rsp_q, rsp_d;
   logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
   logic [7:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic wr_fire;

   // Core state
   sacs_conv_st_t state_q, state_d;
   logic en_q, en_d, start_q, start_d, auto_q, auto_d, done_q, done_d, ie_q, ie_d;
   logic [2:0] div_q, div_d, trig_sel_q, trig_sel_d;
   logic [1:0] chan_buf_q, chan_buf_d, mux_q, mux_d;
   logic [7:0] result_q, result_d;
   logic [4:0] cnt_q, cnt_d, end_q, end_d, shat_q, shat_d;
   logic first_q, first_d, auto_conv_q, auto_conv_d, lock_q, lock_d;
   logic sh_q, sh_d, active_q, active_d, irq_q, irq_d;
   logic trig_prev_q, trig_prev_d, sleep_prev_q, sleep_prev_d;
   logic trig_lvl, trig_fire, sleep_fire, done_evt;

   always_comb begin
      rsp_d = rsp_q;
      aw_hold_d = aw_hold_q;
      w_hold_d = w_hold_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      wr_fire = aw_hold_q && w_hold_q && !rsp_q.bvalid;
      if (rsp_q.bvalid && S_AXI_REQ.bready) begin
         rsp_d.bvalid = 1'b0;
      end
      if (S_AXI_REQ.awvalid && rsp_q.awready) begin
         aw_hold_d = 1'b1;
         awaddr_d = S_AXI_REQ.awaddr;
      end
      if (S_AXI_REQ.wvalid && rsp_q.wready) begin
         w_hold_d = 1'b1;
         wdata_d = S_AXI_REQ.wdata;
         wstrb_d = S_AXI_REQ.wstrb;
      end
      if (wr_fire) begin
         aw_hold_d = 1'b0;
         w_hold_d = 1'b0;
         rsp_d.bvalid = 1'b1;
         rsp_d.bresp = (awaddr_q == OFS_CTRL || awaddr_q == OFS_CHAN || awaddr_q == OFS_RESULT ||
                        awaddr_q == OFS_TRIG) ? RESP_OKAY : RESP_SLVERR;
      end
      rsp_d.awready = !aw_hold_d && !rsp_d.bvalid;
      rsp_d.wready = !w_hold_d && !rsp_d.bvalid;
      if (rsp_q.rvalid && S_AXI_REQ.rready) begin
         rsp_d.rvalid = 1'b0;
      end
      if (S_AXI_REQ.arvalid && rsp_q.arready) begin
         rsp_d.rvalid = 1'b1;
         rsp_d.rresp = RESP_OKAY;
         rsp_d.rdata = 32'h0000_0000;
         unique case (S_AXI_REQ.araddr)
            OFS_CTRL: begin
               // Start reads one throughout a conversion
               rsp_d.rdata[7:0] = {en_q, start_q | active_q, auto_q, done_q, ie_q, div_q};
            end
            OFS_CHAN: rsp_d.rdata[1:0] = chan_buf_q;
            OFS_RESULT: rsp_d.rdata[7:0] = result_q;
            OFS_TRIG: rsp_d.rdata[2:0] = trig_sel_q;
            default: rsp_d.rresp = RESP_SLVERR;
         endcase
      end
      rsp_d.arready = !rsp_d.rvalid;
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         rsp_q <= '0;
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         rsp_q <= rsp_d;
         aw_hold_q <= aw_hold_d;
         w_hold_q <= w_hold_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
      end
   end

   sacs_prescaler u_presc (
      .clk(SYS_CLK),
      .rst(RST),
      .run(en_q),
      .restart(trig_fire),
      .div_sel(div_q),
      .tick(tick)
   );

   // Source zero is free running and never forms an edge
   assign trig_lvl = (trig_sel_q == TRIG_FREE) ? 1'b0 : trig_s[3'(trig_sel_q - 3'h1)];

   always_comb begin
      state_d = state_q;
      en_d = en_q;
      start_d = start_q;
      auto_d = auto_q;
      done_d = done_q;
      ie_d = ie_q;
      div_d = div_q;
      trig_sel_d = trig_sel_q;
      chan_buf_d = chan_buf_q;
      result_d = result_q;
      cnt_d = cnt_q;
      end_d = end_q;
      shat_d = shat_q;
      first_d = first_q;
      auto_conv_d = auto_conv_q;
      lock_d = lock_q;
      sh_d = 1'b0;
      done_evt = 1'b0;
      trig_prev_d = trig_lvl;
      sleep_prev_d = SLEEP_HALT;
      mux_d = lock_q ? mux_q : chan_buf_q;
      if (wr_fire && wstrb_q[0]) begin
         unique case (awaddr_q)
            OFS_CTRL: begin
               en_d = wdata_q[CTRL_EN_BIT];
               auto_d = wdata_q[CTRL_AUTO_BIT];
               ie_d = wdata_q[CTRL_IE_BIT];
               div_d = wdata_q[CTRL_DIV_LSB +: 3];
               // Zero written to start is ignored
               if (wdata_q[CTRL_START_BIT] && wdata_q[CTRL_EN_BIT]) begin
                  start_d = 1'b1;
               end
               if (wdata_q[CTRL_DONE_BIT]) begin
                  done_d = 1'b0;
               end
               if (!en_q && wdata_q[CTRL_EN_BIT]) begin
                  first_d = 1'b1;
               end
            end
            OFS_CHAN: chan_buf_d = wdata_q[CHAN_LSB +: 2];
            OFS_TRIG: trig_sel_d = wdata_q[TRIG_LSB +: 3];
            default: begin
            end
         endcase
      end
      sleep_fire = SLEEP_HALT && !sleep_prev_q && en_q && !auto_q && ie_q && state_q == ST_IDLE && !start_q;
      if (sleep_fire) begin
         start_d = 1'b1;
      end
      // Edges during a conversion or a pending start are dropped
      trig_fire = auto_q && en_q && trig_lvl && !trig_prev_q && state_q == ST_IDLE && !start_q;
      if (trig_fire) begin
         start_d = 1'b1;
         auto_conv_d = 1'b1;
      end
      unique case (state_q)
         ST_IDLE: begin
            if (tick && start_q && en_q) begin
               state_d = ST_CONV;
               lock_d = 1'b1;
               if (first_q) begin
                  cnt_d = CNT_RST;
                  end_d = FIRST_END;
                  shat_d = FIRST_SH;
               end else if (auto_conv_q) begin
                  cnt_d = AUTO_START;
                  end_d = AUTO_END;
                  shat_d = AUTO_SH;
               end else begin
                  cnt_d = CNT_RST;
                  end_d = NORMAL_END;
                  shat_d = NORMAL_SH;
               end
            end
         end
         ST_CONV: begin
            if (tick) begin
               cnt_d = 5'(cnt_q + 5'h01);
               if (cnt_d == shat_q) begin
                  sh_d = 1'b1;
               end
               if (cnt_d == 5'(end_q - 5'h01)) begin
                  lock_d = 1'b0;
               end
               if (cnt_d == end_q) begin
                  done_evt = 1'b1;
               end
            end
         end
      endcase
      if (done_evt) begin
         // Set wins over a same-cycle software clear
         result_d = over_s ? SAT_CODE : cmp_s;
         done_d = 1'b1;
         first_d = 1'b0;
         auto_conv_d = 1'b0;
         if (auto_q && trig_sel_q == TRIG_FREE) begin
            // Restart at once; mux already tracked the buffer in the last cycle
            cnt_d = CNT_RST;
            end_d = NORMAL_END;
            shat_d = NORMAL_SH;
            lock_d = 1'b1;
         end else begin
            state_d = ST_IDLE;
            start_d = 1'b0;
         end
      end
      // Disabling aborts any conversion
      if (!en_d) begin
         state_d = ST_IDLE;
         start_d = 1'b0;
         lock_d = 1'b0;
         auto_conv_d = 1'b0;
      end
      active_d = state_d == ST_CONV;
      irq_d = done_d && ie_d;
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         state_q <= ST_IDLE;
         en_q <= 1'b0;
         start_q <= 1'b0;
         auto_q <= 1'b0;
         done_q <= 1'b0;
         ie_q <= 1'b0;
         div_q <= DIV_RST;
         trig_sel_q <= TRIG_RST;
         chan_buf_q <= CHAN_RST;
         mux_q <= CHAN_RST;
         result_q <= RESULT_RST;
         cnt_q <= CNT_RST;
         end_q <= NORMAL_END;
         shat_q <= NORMAL_SH;
         first_q <= 1'b0;
         auto_conv_q <= 1'b0;
         lock_q <= 1'b0;
         sh_q <= 1'b0;
         active_q <= 1'b0;
         irq_q <= 1'b0;
         trig_prev_q <= 1'b0;
         sleep_prev_q <= 1'b0;
      end else begin
         state_q <= state_d;
         en_q <= en_d;
         start_q <= start_d;
         auto_q <= auto_d;
         done_q <= done_d;
         ie_q <= ie_d;
         div_q <= div_d;
         trig_sel_q <= trig_sel_d;
         chan_buf_q <= chan_buf_d;
         mux_q <= mux_d;
         result_q <= result_d;
         cnt_q <= cnt_d;
         end_q <= end_d;
         shat_q <= shat_d;
         first_q <= first_d;
         auto_conv_q <= auto_conv_d;
         lock_q <= lock_d;
         sh_q <= sh_d;
         active_q <= active_d;
         irq_q <= irq_d;
         trig_prev_q <= trig_prev_d;
         sleep_prev_q <= sleep_prev_d;
      end
   end

   assign S_AXI_RSP = rsp_q;
   assign ANALOG_ENABLE = en_q;
   assign MUX_SEL = mux_q;
   assign SAMPLE_HOLD = sh_q;
   assign CONV_ACTIVE = active_q;
   assign CONV_IRQ = irq_q;

   // Independent tick count since conversion start, for checking only
   logic [4:0] hlp_ticks_q;
   always_ff @(posedge SYS_CLK) begin
      if (RST || state_q == ST_IDLE || (done_evt && state_d == ST_CONV)) begin
         hlp_ticks_q <= 5'h00;
      end else if (tick) begin
         hlp_ticks_q <= 5'(hlp_ticks_q + 5'h01);
      end
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   chk_presc_held: assert property (!en_q && $past(!en_q) |-> !tick)
      else $error("converter tick while disabled");
   chk_start_tick: assert property (state_q == ST_IDLE && tick && start_q && en_q && en_d |=> active_q)
      else $error("start not taken on converter tick");
   chk_conv_length: assert property (done_evt |-> hlp_ticks_q == (first_q ? 5'h18 : 5'h0C))
      else $error("conversion length wrong");
   chk_sh_point: assert property (sh_d |-> hlp_ticks_q == (first_q ? 5'h0F : (auto_conv_q ? 5'h00 : 5'h02)))
      else $error("sample point misplaced");
   chk_done_result: assert property (done_evt && en_d |=> done_q && result_q == ($past(over_s) ? 8'hFF : $past(cmp_s)))
      else $error("result and flag not updated together");
   chk_start_clear: assert property (done_evt && !(auto_q && trig_sel_q == TRIG_FREE) |=> !start_q && !active_q)
      else $error("start bit not cleared at completion");
   chk_free_run: assert property (done_evt && en_d && auto_q && trig_sel_q == TRIG_FREE |=> active_q && start_q)
      else $error("free running did not restart");
   chk_chan_frozen: assert property (lock_q && $past(lock_q) |-> $stable(MUX_SEL))
      else $error("channel changed while locked");
   chk_chan_release: assert property (done_evt |-> !lock_q)
      else $error("channel still locked at completion");
   chk_trig_restart: assert property (trig_fire && en_d |=> start_q ##1 !tick)
      else $error("trigger did not restart prescaler");
   chk_start_reads: assert property (active_q |-> start_q)
      else $error("start bit low during conversion");
   chk_sleep_start: assert property (sleep_fire && en_d |=> start_q)
      else $error("sleep entry did not request conversion");
   chk_irq_raise: assert property (done_q && ie_q |-> CONV_IRQ)
      else $error("interrupt request missing");

   cov_first_done: cover property (done_evt && first_q);
   cov_free_restart: cover property (done_evt && auto_q && trig_sel_q == TRIG_FREE);
   cov_auto_trig: cover property (trig_fire ##[1:600] done_evt);
   cov_sleep_conv: cover property (sleep_fire ##[1:900] CONV_IRQ);
endmodule
`default_nettype wire

//--- sacs_pkg.sv
// Purpose: Shared constants and types for the conversion sequencer
// Assumes: AXI4-Lite with 8-bit byte addresses and 32-bit data
// Notes: Conversion counts are in converter clock cycles
package sacs_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CHAN = 8'h04;
   localparam logic [7:0] OFS_RESULT = 8'h08;
   localparam logic [7:0] OFS_TRIG = 8'h0C;
   // Control, channel and trigger register field positions
   localparam int CTRL_EN_BIT = 7;
   localparam int CTRL_START_BIT = 6;
   localparam int CTRL_AUTO_BIT = 5;
   localparam int CTRL_DONE_BIT = 4;
   localparam int CTRL_IE_BIT = 3;
   localparam int CTRL_DIV_LSB = 0;
   localparam int CHAN_LSB = 0;
   localparam int TRIG_LSB = 0;
   // Values after reset
   localparam logic [2:0] DIV_RST = 3'h0;
   localparam logic [1:0] CHAN_RST = 2'h0;
   localparam logic [2:0] TRIG_RST = 3'h0;
   localparam logic [7:0] RESULT_RST = 8'h00;
   localparam logic [6:0] PRESC_RST = 7'h00;
   localparam logic [4:0] CNT_RST = 5'h00;
   // Conversion timing in converter cycles
   localparam logic [4:0] NORMAL_END = 5'h0D;  // 13
   localparam logic [4:0] NORMAL_SH = 5'h03;   // 3
   localparam logic [4:0] FIRST_END = 5'h19;   // 25
   localparam logic [4:0] FIRST_SH = 5'h10;    // 16
   localparam logic [4:0] AUTO_START = 5'h01;  // trigger-aligned cycle already spent
   localparam logic [4:0] AUTO_SH = 5'h02;     // 2 after trigger
   localparam logic [4:0] AUTO_END = 5'h0E;    // 13.5 rounded onto whole ticks
   localparam logic [7:0] SAT_CODE = 8'hFF;
   localparam logic [2:0] TRIG_FREE = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [7:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [7:0] araddr;
      logic arvalid;
      logic rready;
   } sacs_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sacs_axi_rsp_t;

   typedef enum logic {ST_IDLE, ST_CONV} sacs_conv_st_t;
endpackage

//--- sacs_sync.sv
// Purpose: Two-stage synchroniser for asynchronous inputs
// Assumes: Each bit is an independent level
// Notes: Multi-bit values may tear for one cycle while changing
`timescale 1ns/1ps
`default_nettype none
module sacs_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
      end
   end

   assign dout = s2_q;
endmodule
`default_nettype wire

//--- sacs_prescaler.sv
// Purpose: Divides the system clock into a converter-cycle strobe
// Assumes: Strobe is one system cycle wide
// Notes: Held cleared while not running or on restart
`timescale 1ns/1ps
`default_nettype none
module sacs_prescaler
   import sacs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic restart,
   input wire logic [2:0] div_sel,
   output logic tick
);
   logic [6:0] cnt_q;
   logic [6:0] cnt_d;
   logic [6:0] last;
   logic tick_q;
   logic tick_d;

   always_comb begin
      // Codes 0 and 1 both divide by two
      if (div_sel == 3'h0) begin
         last = 7'h01;
      end else begin
         last = 7'((7'h01 << div_sel) - 7'h01);
      end
      cnt_d = 7'(cnt_q + 7'h01);
      tick_d = 1'b0;
      if (!run || restart) begin
         cnt_d = PRESC_RST;
      end else if (cnt_q == last) begin
         cnt_d = PRESC_RST;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= PRESC_RST;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;
endmodule
`default_nettype wire

//--- sacs_analog_model.sv
// Purpose: Stand-in for the analog multiplexer and comparator array
// Assumes: Channel is taken at the sample pulse, code held after it
// Notes: Garbage on the result lines while the converter is off
`timescale 1ns/1ps
`default_nettype none
module sacs_analog_model (
   input wire logic clk,
   input wire logic en,
   input wire logic [1:0] sel,
   input wire logic sh,
   input wire logic [31:0] codes,
   input wire logic [3:0] over,
   output logic [7:0] res,
   output logic ovr
);
   logic [1:0] held = 2'h0;
   initial res = 8'h00;
   initial ovr = 1'b0;
   always @(posedge clk) begin
      if (sh) begin
         held <= sel;
      end
      if (!en) begin
         res <= ~res;  // Unpowered array gives no stable code
      end else begin
         res <= codes[{held, 3'h0} +: 8];
      end
      ovr <= en & over[held];
   end
endmodule
`default_nettype wire

//--- tb_top.sv
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Short divides, except one slow free-running check at the largest divide
// Notes: Read and timing results are matched against queued notes
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import sacs_pkg::*;
;
   logic SYS_CLK = 1'b0;
   logic RST = 1'b1;
   sacs_axi_req_t req = '0;
   sacs_axi_rsp_t rsp;
   logic [6:0] trig = 7'h00;
   logic sleep = 1'b0;
   logic [7:0] cres;
   logic c_over, ena, sh, act, irq;
   logic [1:0] msel;
   logic [31:0] codes = 32'h0;
   logic [31:0] seed = 32'd57;
   logic [33:0] rq[$];
   logic [33:0] tq[$];
   int miscompares = 0;
   int cmp_count = 0;
   int cnt = 0;
   int shc = 0;
   time t0;

   initial forever #2 SYS_CLK = ~SYS_CLK;

   sacs_sequencer i_dut (.SYS_CLK(SYS_CLK), .RST(RST), .S_AXI_REQ(req), .S_AXI_RSP(rsp),
      .TRIG_IN(trig), .CMP_RESULT(cres), .CMP_OVER(c_over), .SLEEP_HALT(sleep),
      .ANALOG_ENABLE(ena), .MUX_SEL(msel), .SAMPLE_HOLD(sh), .CONV_ACTIVE(act), .CONV_IRQ(irq));

   sacs_analog_model i_ana (.clk(SYS_CLK), .en(ena), .sel(msel), .sh(sh), .codes(codes),
      .over(4'h8), .res(cres), .ovr(c_over));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   task automatic close_out();
      $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(inout int n, input int lim);
      @(posedge SYS_CLK);
      n++;
      if (n > lim) begin
         miscompares++;
         $display("MISMATCH t=%0t wait ran out", $time);
         close_out();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      logic fin;
      n = 0;
      fin = 1'b0;
      @(posedge SYS_CLK);
      req.awaddr <= a;
      req.wdata <= {24'h0, d};
      req.wstrb <= 4'hF;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      while (!fin) begin
         tick(n, 200);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid) begin
            req.bready <= 1'b0;
            fin = 1'b1;
         end
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      logic fin;
      n = 0;
      fin = 1'b0;
      @(posedge SYS_CLK);
      rq.push_back({r, d});
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      while (!fin) begin
         tick(n, 200);
         if (rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid) begin
            req.rready <= 1'b0;
            fin = 1'b1;
         end
      end
   endtask

   task automatic wait_conv();
      int n;
      n = 0;
      while (act !== 1'b1) tick(n, 600);
      while (act !== 1'b0) tick(n, 2000);
      @(posedge SYS_CLK);
   endtask

   task automatic wait_sh();
      int n;
      n = 0;
      do tick(n, 2000); while (sh !== 1'b1);
   endtask

   // Watcher: pops the oldest note whenever a read or a conversion ends
   always @(posedge SYS_CLK) begin
      if (rsp.rvalid === 1'b1 && req.rready && rq.size() > 0) begin
         check({rsp.rresp, rsp.rdata}, rq.pop_front());
      end
      if (act === 1'b1) begin
         cnt <= cnt + 1;
      end else begin
         if (cnt != 0 && tq.size() > 0) check({2'h0, shc[15:0], cnt[15:0]}, tq.pop_front());
         cnt <= 0;
      end
      if (sh === 1'b1) shc <= cnt;
   end

   initial begin
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         codes[i*8 +: 8] = seed[7:0];
      end
      repeat (16) @(posedge SYS_CLK);
      RST <= 1'b0;
      rd(OFS_CTRL, 32'h0, RESP_OKAY);
      rd(OFS_RESULT, 32'h0, RESP_OKAY);
      rd(8'h10, 32'h0, RESP_SLVERR);
      wr(OFS_CHAN, 8'h02);
      // Model has no resolution loss, so fast divides stand in for 50-200 kHz
      tq.push_back({2'h0, 16'd32, 16'd50});
      wr(OFS_CTRL, 8'hC0);
      wait_conv();
      rd(OFS_CTRL, 32'h90, RESP_OKAY);
      rd(OFS_RESULT, {24'h0, codes[23:16]}, RESP_OKAY);
      wr(OFS_CHAN, 8'h03);
      tq.push_back({2'h0, 16'd12, 16'd52});
      wr(OFS_CTRL, 8'hC2);
      // Channel rewritten well after one converter cycle
      wr(OFS_CTRL, 8'h82);
      rd(OFS_CTRL, 32'hD2, RESP_OKAY);
      wr(OFS_CHAN, 8'h01);
      check({32'h0, msel}, 34'h3);
      wait_conv();
      check({32'h0, msel}, 34'h1);
      rd(OFS_RESULT, 32'hFF, RESP_OKAY);
      wr(OFS_CTRL, 8'h99);
      rd(OFS_CTRL, 32'h89, RESP_OKAY);
      check({33'h0, irq}, 34'h0);
      tq.push_back({2'h0, 16'd6, 16'd26});
      sleep <= 1'b1;
      wait_conv();
      sleep <= 1'b0;
      check({33'h0, irq}, 34'h1);
      rd(OFS_RESULT, {24'h0, codes[15:8]}, RESP_OKAY);
      wr(OFS_TRIG, 8'h01);
      tq.push_back({2'h0, 16'd2, 16'd26});
      wr(OFS_CTRL, 8'hA0);
      trig <= 7'h01;
      wait_conv();
      trig <= 7'h00;
      wr(OFS_TRIG, 8'h00);
      wr(OFS_CTRL, 8'hE7);
      wait_sh();
      t0 = $time;
      wait_sh();
      check(34'(($time - t0) / 4), 34'd1664);
      wr(OFS_CHAN, 8'h00);
      check({32'h0, msel}, 34'h1);
      rd(OFS_CTRL, 32'hF7, RESP_OKAY);
      wr(OFS_CTRL, 8'h00);
      repeat (3) @(posedge SYS_CLK);
      check({32'h0, ena, act}, 34'h0);
      close_out();
   end
endmodule
`default_nettype wire
